/* hw/pmbus_cmd_defs.vh */
/*
 * Constants for the command decoder and control bank of the power
 * management serial slave: command codes, field positions, reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef PMBUS_CMD_DEFS_VH
`define PMBUS_CMD_DEFS_VH
// Operation
// - Act only on the listed command codes and the seven custom registers.
// - Clear, store and restore commands carry no data; act on the code alone.
// - Store command copies user registers into non-volatile cells.
// - Restore command overwrites user registers from non-volatile cells.
// - Clear command zeroes every latched status flag.
// - Unsupported codes and their data are acknowledged but change nothing.
// - Unsupported traffic sets the communication fault flag and pulls alert low.
// - Run control register at 01h, bit 7 requests converter on.
// - Bits 5:2 select margin off, low or high, ignoring or acting on faults.
// - Run control bits 6, 1, 0 are stored but have no effect.
// - Enable config bits 4, 1, 0 read as one; bits 7:5 unused.
// - Bit 3 obeys run bit (default 0); bit 2 obeys pin (default 1).
// - Command select 0, pin select 1: enable follows the pin only.
// - Command select 1, pin select 0: enable follows the run bit only.
// - Both selects 1: enable needs run bit and pin together.
// - Both selects 0: enable once address detection has finished.
// - Write lock 80h, 40h, 20h leave lock, run, enable config writable.
// - Lock 00h allows all writes; other lock values are invalid data.
// - Write lock command carries exactly one data byte.
// - Clear at 03h zeroes flags, releases alert; persisting faults reassert.
// - Store command code is 11h; device may be busy during copy.
// - Restore command code is 12h; device may be busy during copy.
// - Communication fault flag is status low bit 1, latched until cleared.

// ============================================================
// Command codes
`define CMD_RUN_CTRL      8'h01
`define CMD_ENABLE_CFG    8'h02
`define CMD_CLEAR_FLAGS   8'h03
`define CMD_WRITE_LOCK    8'h10
`define CMD_STORE_ALL     8'h11
`define CMD_RESTORE_ALL   8'h12
`define CMD_STATUS_BYTE   8'h78
`define CMD_STATUS_WORD   8'h79
`define CMD_CUSTOM_FIRST  8'hD0
`define CMD_CUSTOM_LAST   8'hD6

// ============================================================
// Fields and values
`define RUN_BIT           7
`define MARGIN_HI         5
`define MARGIN_LO         2
`define CFG_CMD_BIT       3
`define CFG_PIN_BIT       2
`define CFG_FIXED_ONES    8'h13
`define CFG_RESET         8'h17
`define RUN_RESET         8'h00
`define LOCK_RESET        8'h00
`define LOCK_ALL          8'h80
`define LOCK_RUN_OK       8'h40
`define LOCK_CFG_OK       8'h20
`define LOCK_NONE         8'h00
`define CML_BIT           1
`define NVM_COPY_CYCLES   16
`define SLAVE_ADDR_HI     3'h1
`endif

/* hw/pin_sync.v */
/*
 * Two-flop synchroniser for one level from outside the clock domain.
 * Assumes a free-running clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter RESET_VAL = 1'b1
) (
   input  wire clk_i,
   input  wire rstn_i,
   input  wire d_i,
   output reg  q_o
);
   reg meta_reg;

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_reg <= RESET_VAL;
         q_o      <= RESET_VAL;
      end else begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule
`default_nettype wire

/* hw/pmbus_command_control_bank.v */
/*
 * Serial-bus slave with command decoder and control bank for a step-down
 * controller: run and margin control, enable-source selection, write
 * lock, send-byte commands and the status word.
 * Assumes bus clock and data arrive as open-drain pins sampled by the
 * 100 MHz core clock; non-volatile cells are modelled by flip-flops.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_cmd_defs.vh"
module pmbus_command_control_bank #(
   parameter NVM_CYCLES = `NVM_COPY_CYCLES
) (
   // Clock and reset
   input  wire       REF_CLK_I,
   input  wire       RSTN_I,
   // Serial bus pins
   input  wire       BUS_CLK_I,
   input  wire       BUS_DATA_I,
   output reg        BUS_DATA_O,
   output reg        BUS_DATA_OE_O,
   output reg        ALERTN_O,
   output reg        ALERTN_OE_O,
   // Converter side
   input  wire       EN_PIN_I,
   input  wire [3:0] ADDR_SEL_I,
   input  wire       ADDR_DONE_I,
   input  wire [6:0] FAULT_COND_I,
   output reg        CONV_ENABLE_O,
   output reg  [3:0] MARGIN_SEL_O,
   output reg        BUSY_O
);
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_CMD  = 3'h2;
   localparam ST_DATA = 3'h3;
   localparam ST_READ = 3'h4;
   localparam ST_SKIP = 3'h5;

   wire scl_s;
   wire sda_s;
   wire en_s;
   reg  scl_d_reg;
   reg  sda_d_reg;

   pin_sync #(.RESET_VAL(1'b1)) u_scl (.clk_i(REF_CLK_I), .rstn_i(RSTN_I),
      .d_i(BUS_CLK_I), .q_o(scl_s));
   pin_sync #(.RESET_VAL(1'b1)) u_sda (.clk_i(REF_CLK_I), .rstn_i(RSTN_I),
      .d_i(BUS_DATA_I), .q_o(sda_s));
   pin_sync #(.RESET_VAL(1'b1)) u_en (.clk_i(REF_CLK_I), .rstn_i(RSTN_I),
      .d_i(EN_PIN_I), .q_o(en_s));

   wire scl_rise = scl_s & ~scl_d_reg;
   wire scl_fall = ~scl_s & scl_d_reg;
   wire start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   wire stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // ============================================================
   // Registers
   reg [7:0]  run_reg;
   reg [7:0]  cfg_reg;
   reg [7:0]  lock_reg;
   reg [7:0]  custom_reg [0:6];
   reg [7:0]  nvm_run_reg;
   reg [7:0]  nvm_cfg_reg;
   reg [7:0]  nvm_custom_reg [0:6];
   reg [6:0]  flags_reg;
   reg [2:0]  state_reg;
   reg [3:0]  bit_cnt_reg;
   reg [7:0]  shift_reg;
   reg [7:0]  cmd_reg;
   reg [7:0]  data_reg;
   reg        rd_hi_reg;
   reg        ack_pend_reg;
   reg        is_read_reg;
   reg        data_seen_reg;
   reg        bad_reg;
   reg [15:0] copy_cnt_reg;
   reg [1:0]  copy_op_reg;
   integer    i;

   // Returns 1 for every code the device acts on
   function known_cmd;
      input [7:0] c;
      begin
         known_cmd = (c == `CMD_RUN_CTRL) || (c == `CMD_ENABLE_CFG) ||
            (c == `CMD_CLEAR_FLAGS) || (c == `CMD_WRITE_LOCK) ||
            (c == `CMD_STORE_ALL) || (c == `CMD_RESTORE_ALL) ||
            (c == `CMD_STATUS_BYTE) || (c == `CMD_STATUS_WORD) ||
            ((c >= `CMD_CUSTOM_FIRST) && (c <= `CMD_CUSTOM_LAST));
      end
   endfunction

   // Write permission under the current lock value
   function write_ok;
      input [7:0] c;
      input [7:0] lk;
      begin
         case (lk)
            `LOCK_NONE:   write_ok = 1'b1;
            `LOCK_CFG_OK: write_ok = (c == `CMD_WRITE_LOCK) ||
               (c == `CMD_RUN_CTRL) || (c == `CMD_ENABLE_CFG);
            `LOCK_RUN_OK: write_ok = (c == `CMD_WRITE_LOCK) ||
               (c == `CMD_RUN_CTRL);
            default:      write_ok = (c == `CMD_WRITE_LOCK);
         endcase
      end
   endfunction

   // Byte returned for a read of code c
   function [7:0] read_byte;
      input [7:0] c;
      input       hi;
      begin
         if (c == `CMD_RUN_CTRL)
            read_byte = run_reg;
         else if (c == `CMD_ENABLE_CFG)
            read_byte = cfg_reg | `CFG_FIXED_ONES;
         else if (c == `CMD_WRITE_LOCK)
            read_byte = lock_reg;
         else if (c == `CMD_STATUS_BYTE || (c == `CMD_STATUS_WORD && !hi))
            read_byte = {1'b0, ~CONV_ENABLE_O, flags_reg[3:0],
                         flags_reg[`CML_BIT], 1'b0};
         else if (c == `CMD_STATUS_WORD)
            read_byte = {flags_reg[6:4], 5'h00};
         else if (c >= `CMD_CUSTOM_FIRST && c <= `CMD_CUSTOM_LAST)
            read_byte = custom_reg[c[2:0]];
         else
            read_byte = 8'hFF;
      end
   endfunction

   wire valid_lock = (data_reg == `LOCK_ALL) || (data_reg == `LOCK_RUN_OK) ||
      (data_reg == `LOCK_CFG_OK) || (data_reg == `LOCK_NONE);
   wire [7:0] addr_byte = {`SLAVE_ADDR_HI, ADDR_SEL_I, 1'b0};
   wire       busy = (copy_cnt_reg != 16'h0000);

   // Converter enable source selection
   reg enable_next;
   always @* begin
      case ({cfg_reg[`CFG_CMD_BIT], cfg_reg[`CFG_PIN_BIT]})
         2'b01:   enable_next = en_s;
         2'b10:   enable_next = run_reg[`RUN_BIT];
         2'b11:   enable_next = run_reg[`RUN_BIT] & en_s;
         default: enable_next = ADDR_DONE_I;
      endcase
   end

   // Margin field: only documented codes take effect
   reg [3:0] margin_next;
   always @* begin
      case (run_reg[`MARGIN_HI:`MARGIN_LO])
         4'h5, 4'h6, 4'h9, 4'hA: margin_next = run_reg[`MARGIN_HI:`MARGIN_LO];
         default:                margin_next = 4'h0;
      endcase
   end

   // ============================================================
   // Bus protocol and command execution
   always @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         scl_d_reg     <= 1'b1;
         sda_d_reg     <= 1'b1;
         run_reg       <= `RUN_RESET;
         cfg_reg       <= `CFG_RESET;
         lock_reg      <= `LOCK_RESET;
         nvm_run_reg   <= `RUN_RESET;
         nvm_cfg_reg   <= `CFG_RESET;
         for (i = 0; i < 7; i = i + 1) begin
            custom_reg[i]     <= 8'h00;
            nvm_custom_reg[i] <= 8'h00;
         end
         flags_reg     <= 7'h00;
         state_reg     <= ST_IDLE;
         bit_cnt_reg   <= 4'h0;
         shift_reg     <= 8'h00;
         cmd_reg       <= 8'h00;
         data_reg      <= 8'h00;
         rd_hi_reg     <= 1'b0;
         ack_pend_reg  <= 1'b0;
         is_read_reg   <= 1'b0;
         data_seen_reg <= 1'b0;
         bad_reg       <= 1'b0;
         copy_cnt_reg  <= 16'h0000;
         copy_op_reg   <= 2'b00;
         BUS_DATA_O    <= 1'b0;
         BUS_DATA_OE_O <= 1'b0;
         ALERTN_O      <= 1'b0;
         ALERTN_OE_O   <= 1'b0;
         CONV_ENABLE_O <= 1'b0;
         MARGIN_SEL_O  <= 4'h0;
         BUSY_O        <= 1'b0;
      end else begin
         scl_d_reg     <= scl_s;
         sda_d_reg     <= sda_s;
         CONV_ENABLE_O <= enable_next;
         MARGIN_SEL_O  <= margin_next;
         BUSY_O        <= busy;
         ALERTN_OE_O   <= |flags_reg;
         // Persisting fault conditions set again even in a clear cycle
         flags_reg     <= flags_reg | FAULT_COND_I;

         // Non-volatile copy runs for a fixed time; bus is ignored then
         if (busy) begin
            copy_cnt_reg <= copy_cnt_reg - 16'h0001;
            if (copy_cnt_reg == 16'h0001) begin
               if (copy_op_reg == 2'b01) begin
                  nvm_run_reg <= run_reg;
                  nvm_cfg_reg <= cfg_reg;
                  for (i = 0; i < 7; i = i + 1)
                     nvm_custom_reg[i] <= custom_reg[i];
               end else begin
                  run_reg <= nvm_run_reg;
                  cfg_reg <= nvm_cfg_reg;
                  for (i = 0; i < 7; i = i + 1)
                     custom_reg[i] <= nvm_custom_reg[i];
               end
            end
         end else if (start_ev) begin
            state_reg     <= ST_ADDR;
            bit_cnt_reg   <= 4'h0;
            ack_pend_reg  <= 1'b0;
            BUS_DATA_OE_O <= 1'b0;
         end else if (stop_ev) begin
            state_reg     <= ST_IDLE;
            BUS_DATA_OE_O <= 1'b0;
            if (bad_reg)
               flags_reg[`CML_BIT] <= 1'b1;
            else if (!is_read_reg && !data_seen_reg) begin
               if (cmd_reg == `CMD_CLEAR_FLAGS)
                  flags_reg <= FAULT_COND_I;
               else if (cmd_reg == `CMD_STORE_ALL) begin
                  copy_cnt_reg <= NVM_CYCLES[15:0];
                  copy_op_reg  <= 2'b01;
               end else if (cmd_reg == `CMD_RESTORE_ALL) begin
                  copy_cnt_reg <= NVM_CYCLES[15:0];
                  copy_op_reg  <= 2'b10;
               end
            end else if (!is_read_reg && write_ok(cmd_reg, lock_reg)) begin
               // Blocked writes fall through unchanged
               if (cmd_reg == `CMD_RUN_CTRL)
                  run_reg <= data_reg;
               else if (cmd_reg == `CMD_ENABLE_CFG)
                  cfg_reg <= data_reg | `CFG_FIXED_ONES;
               else if (cmd_reg == `CMD_WRITE_LOCK) begin
                  if (valid_lock)
                     lock_reg <= data_reg;
                  else
                     flags_reg[`CML_BIT] <= 1'b1;
               end else if (cmd_reg >= `CMD_CUSTOM_FIRST &&
                            cmd_reg <= `CMD_CUSTOM_LAST)
                  custom_reg[cmd_reg[2:0]] <= data_reg;
            end
            bad_reg       <= 1'b0;
            is_read_reg   <= 1'b0;
            data_seen_reg <= 1'b0;
         end else if (scl_fall) begin
            if (ack_pend_reg) begin
               // Drive acknowledge low for the ninth clock
               ack_pend_reg  <= 1'b0;
               BUS_DATA_O    <= 1'b0;
               BUS_DATA_OE_O <= 1'b1;
            end else if (state_reg == ST_READ && bit_cnt_reg < 4'h8) begin
               BUS_DATA_O    <= 1'b0;
               BUS_DATA_OE_O <= ~shift_reg[7];
               shift_reg     <= {shift_reg[6:0], 1'b1};
            end else
               BUS_DATA_OE_O <= 1'b0;
         end else if (scl_rise && state_reg != ST_IDLE) begin
            if (bit_cnt_reg == 4'h8) begin
               bit_cnt_reg <= 4'h0;
               if (state_reg == ST_READ) begin
                  if (sda_s)
                     state_reg <= ST_SKIP;
                  else begin
                     rd_hi_reg <= 1'b1;
                     shift_reg <= read_byte(cmd_reg, 1'b1);
                  end
               end
            end else begin
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
               if (state_reg != ST_READ)
                  shift_reg <= {shift_reg[6:0], sda_s};
               if (bit_cnt_reg == 4'h7 && state_reg != ST_READ) begin
                  case (state_reg)
                     ST_ADDR: begin
                        if ({shift_reg[6:0], 1'b0} == addr_byte) begin
                           ack_pend_reg <= 1'b1;
                           if (sda_s) begin
                              state_reg   <= ST_READ;
                              is_read_reg <= 1'b1;
                              rd_hi_reg   <= 1'b0;
                              // Own ack clock must not count as master ack
                              bit_cnt_reg <= 4'hF;
                              shift_reg   <= read_byte(cmd_reg, 1'b0);
                           end else
                              state_reg <= ST_CMD;
                        end else
                           state_reg <= ST_SKIP;
                     end
                     ST_CMD: begin
                        ack_pend_reg  <= 1'b1;
                        cmd_reg       <= {shift_reg[6:0], sda_s};
                        data_seen_reg <= 1'b0;
                        bad_reg <= ~known_cmd({shift_reg[6:0], sda_s});
                        state_reg     <= ST_DATA;
                     end
                     ST_DATA: begin
                        ack_pend_reg <= 1'b1;
                        if (data_seen_reg)
                           bad_reg <= 1'b1;
                        data_seen_reg <= 1'b1;
                        data_reg      <= {shift_reg[6:0], sda_s};
                     end
                     default: state_reg <= ST_SKIP;
                  endcase
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* verif/pmbus_bank_monitor.sv */
/* Port checker for the command bank, bound onto every instance.
   Assumes one core clock and the async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module pmbus_bank_monitor #(
   parameter NVM_CYCLES = 16
) (
   // Clock and reset
   input wire logic       REF_CLK_I,
   input wire logic       RSTN_I,
   // Bus pins
   input wire logic       BUS_CLK_I,
   input wire logic       BUS_DATA_I,
   input wire logic       BUS_DATA_O,
   input wire logic       BUS_DATA_OE_O,
   input wire logic       ALERTN_O,
   input wire logic       ALERTN_OE_O,
   // Converter side
   input wire logic [3:0] MARGIN_SEL_O,
   input wire logic       BUSY_O
);
   // ============================================================
   // Copy length
   logic [15:0] busy_len_reg;
   always @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         busy_len_reg <= 16'h0000;
      end else begin
         busy_len_reg <= BUSY_O ? busy_len_reg + 16'h0001 : 16'h0000;
      end
   end
   // ============================================================
   // Properties
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RSTN_I);
   property p_od_low; !BUS_DATA_O && !ALERTN_O; endproperty
   a_od_low: assert property (p_od_low)
      else $error("open-drain value not low");
   property p_margin_code;
      MARGIN_SEL_O inside {4'h0, 4'h5, 4'h6, 4'h9, 4'hA};
   endproperty
   a_margin_code: assert property (p_margin_code)
      else $error("illegal margin code");
   property p_copy_len; busy_len_reg <= NVM_CYCLES + 2; endproperty
   a_copy_len: assert property (p_copy_len)
      else $error("copy runs too long");
   property p_copy_end;
      $fell(BUSY_O) |-> $past(busy_len_reg) >= NVM_CYCLES - 1;
   endproperty
   a_copy_end: assert property (p_copy_end)
      else $error("copy ended early");
   property p_copy_deaf; BUSY_O |-> !BUS_DATA_OE_O; endproperty
   a_copy_deaf: assert property (p_copy_deaf)
      else $error("bus answered during copy");
   property p_alert_clear;
      $fell(ALERTN_OE_O) |-> BUS_CLK_I && BUS_DATA_I;
   endproperty
   a_alert_clear: assert property (p_alert_clear)
      else $error("alert released outside a stop");
   property p_margin_at_stop;
      $changed(MARGIN_SEL_O) |-> BUS_CLK_I && BUS_DATA_I;
   endproperty
   a_margin_at_stop: assert property (p_margin_at_stop)
      else $error("margin changed mid frame");
   property p_ack_hold;
      $rose(BUS_CLK_I) |=> $stable(BUS_DATA_OE_O) [*3];
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("data pull changed while clock high");
endmodule
bind pmbus_command_control_bank pmbus_bank_monitor #(
   .NVM_CYCLES(NVM_CYCLES)
) i_pmbus_bank_monitor (
   .REF_CLK_I     (REF_CLK_I),
   .RSTN_I        (RSTN_I),
   .BUS_CLK_I     (BUS_CLK_I),
   .BUS_DATA_I    (BUS_DATA_I),
   .BUS_DATA_O    (BUS_DATA_O),
   .BUS_DATA_OE_O (BUS_DATA_OE_O),
   .ALERTN_O      (ALERTN_O),
   .ALERTN_OE_O   (ALERTN_OE_O),
   .MARGIN_SEL_O  (MARGIN_SEL_O),
   .BUSY_O        (BUSY_O)
);
`default_nettype wire

/* verif/pmbus_host_model.sv */
/* Bus host model: writes, send-bytes and combined reads.
   Assumes the data line is resolved outside with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model #(
   parameter [3:0] ADDR_LOW = 4'hA
) (
   // Clock
   input  wire logic clk_i,
   // Bus lines
   input  wire logic sda_i,
   output var logic  scl_o,
   output var logic  sda_oe_o
);
   logic ack_ok;
   logic smp;
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
      ack_ok = 1'b1;
   end
   // ============================================================
   // Bit level; clock stands high between frames
   task wait_n(input integer n);
      repeat (n) @(negedge clk_i);
   endtask
   task bit_x(input logic oe, output logic s);
      begin
         wait_n(1);
         sda_oe_o = oe;
         wait_n(3);
         scl_o = 1'b1;
         wait_n(4);
         s = sda_i;
         scl_o = 1'b0;
      end
   endtask
   task byte_w(input logic [7:0] b);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) bit_x(~b[i], smp);
         bit_x(1'b0, smp);
         if (smp) ack_ok = 1'b0;
      end
   endtask
   task byte_r(output logic [7:0] b);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) bit_x(1'b0, b[i]);
         bit_x(1'b0, smp); // Not acknowledged: last byte
      end
   endtask
   // ============================================================
   // Framing
   task start_c;
      begin
         wait_n(1);
         sda_oe_o = 1'b1;
         wait_n(4);
         scl_o = 1'b0;
      end
   endtask
   task stop_c;
      begin
         wait_n(1);
         sda_oe_o = 1'b1;
         wait_n(3);
         scl_o = 1'b1;
         wait_n(4);
         sda_oe_o = 1'b0;
         wait_n(16); // Room for the stop to take effect
      end
   endtask
   // Bad codes are sent only when the bench asks for them
   task xfer(input logic [7:0] cmd, input logic [1:0] n,
             input logic [15:0] d);
      begin
         start_c;
         byte_w({3'h1, ADDR_LOW, 1'h0});
         byte_w(cmd);
         if (n > 2'h0) byte_w(d[7:0]);
         if (n > 2'h1) byte_w(d[15:8]);
         stop_c;
      end
   endtask
   task rd(input logic [7:0] cmd, output logic [7:0] d);
      begin
         start_c;
         byte_w({3'h1, ADDR_LOW, 1'h0});
         byte_w(cmd);
         wait_n(1);
         sda_oe_o = 1'b0;
         wait_n(3);
         scl_o = 1'b1;
         wait_n(3);
         start_c;
         byte_w({3'h1, ADDR_LOW, 1'h1});
         byte_r(d);
         stop_c;
      end
   endtask
endmodule
`default_nettype wire

/* verif/pmbus_command_control_bank_tb_top.sv */
/* Top bench for the command bank: register rows, lock, faults, copies.
   Assumes the host model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module pmbus_command_control_bank_tb_top;
   localparam [3:0] ADDR = 4'hA;
   localparam       NVM  = 6; // Short copy keeps the run brief
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        en_pin = 1'b0;
   logic        addr_done = 1'b0;
   logic [6:0]  fault = 7'h00;
   logic [7:0]  rd_val;
   logic        seen_busy = 1'b0;
   logic [29:0] rows [0:12];
   integer      fail_count = 0;
   integer      n_tests = 0;
   integer      k;
   wire         scl, host_oe, data_o, data_oe, alert_o, alert_oe;
   wire         conv_en, busy;
   wire [3:0]   margin;
   wire         sda = ~(host_oe | data_oe);
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (busy === 1'b1) seen_busy <= 1'b1;
   pmbus_command_control_bank #(.NVM_CYCLES(NVM)) i_pmbus_command_control_bank (
      .REF_CLK_I(ref_clk), .RSTN_I(rstn), .BUS_CLK_I(scl),
      .BUS_DATA_I(sda), .BUS_DATA_O(data_o), .BUS_DATA_OE_O(data_oe),
      .ALERTN_O(alert_o), .ALERTN_OE_O(alert_oe), .EN_PIN_I(en_pin),
      .ADDR_SEL_I(ADDR), .ADDR_DONE_I(addr_done), .FAULT_COND_I(fault),
      .CONV_ENABLE_O(conv_en), .MARGIN_SEL_O(margin), .BUSY_O(busy));
   pmbus_host_model #(.ADDR_LOW(ADDR)) i_pmbus_host_model (
      .clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
   // ============================================================
   // Tasks
   task chk(input [8*10:1] what, input [7:0] exp, input [7:0] got);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected %0s: expected %h, seen %h", what, exp, got);
         end
      end
   endtask
   task report_and_stop;
      begin
         if (fail_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
         end else begin
            $display("Simulation failed");
         end
         $finish;
      end
   endtask
   task rd_chk(input [7:0] cmd, input [7:0] exp);
      begin
         i_pmbus_host_model.rd(cmd, rd_val);
         chk("readback", exp, rd_val);
      end
   endtask
   task wr_chk(input [7:0] cmd, input [7:0] data, input [7:0] exp);
      begin
         i_pmbus_host_model.xfer(cmd, 2'h1, {8'h00, data});
         rd_chk(cmd, exp);
      end
   endtask
   task clear_chk(input alert_exp);
      begin
         i_pmbus_host_model.xfer(8'h03, 2'h0, 16'h0000);
         chk("alert", {7'h00, alert_exp}, {7'h00, alert_oe});
      end
   endtask
   task wait_idle;
      for (k = 0; k < 100 && busy !== 1'b0; k = k + 1) @(negedge ref_clk);
   endtask
   task reset_chk;
      begin
         @(negedge ref_clk);
         rstn = 1'b0;
         repeat (16) @(negedge ref_clk);
         rstn = 1'b1;
         repeat (4) @(negedge ref_clk);
         rd_chk(8'h01, 8'h00);
         rd_chk(8'h02, 8'h17);
         rd_chk(8'h10, 8'h00);
         chk("alert", 8'h00, {7'h00, alert_oe});
      end
   endtask
   // ============================================================
   // Sequence; rows are cmd, data, readback, margin, pin, enable
   initial begin
      rows[0]  = {8'h01, 8'h80, 8'h80, 4'h0, 1'h0, 1'h0};
      rows[1]  = {8'h01, 8'h00, 8'h00, 4'h0, 1'h1, 1'h1};
      rows[2]  = {8'h01, 8'h14, 8'h14, 4'h5, 1'h1, 1'h1};
      rows[3]  = {8'h01, 8'h18, 8'h18, 4'h6, 1'h1, 1'h1};
      rows[4]  = {8'h01, 8'h24, 8'h24, 4'h9, 1'h1, 1'h1};
      rows[5]  = {8'h01, 8'h28, 8'h28, 4'hA, 1'h1, 1'h1};
      rows[6]  = {8'h01, 8'h4F, 8'h4F, 4'h0, 1'h1, 1'h1};
      rows[7]  = {8'h02, 8'h08, 8'h1B, 4'h0, 1'h1, 1'h0};
      rows[8]  = {8'h01, 8'h80, 8'h80, 4'h0, 1'h0, 1'h1};
      rows[9]  = {8'h02, 8'h0C, 8'h1F, 4'h0, 1'h0, 1'h0};
      rows[10] = {8'h01, 8'h80, 8'h80, 4'h0, 1'h1, 1'h1};
      rows[11] = {8'h02, 8'hE0, 8'hF3, 4'h0, 1'h0, 1'h1};
      rows[12] = {8'h02, 8'h17, 8'h17, 4'h0, 1'h1, 1'h1};
      reset_chk;
      addr_done = 1'b1;
      for (k = 0; k < 13; k = k + 1) begin
         en_pin = rows[k][1];
         wr_chk(rows[k][29:22], rows[k][21:14], rows[k][13:6]);
         chk("margin", {4'h0, rows[k][5:2]}, {4'h0, margin});
         chk("enable", {7'h00, rows[k][0]}, {7'h00, conv_en});
      end
      wr_chk(8'h10, 8'h80, 8'h80);
      i_pmbus_host_model.ack_ok = 1'b1;
      wr_chk(8'h01, 8'h14, 8'h80);
      chk("ack", 8'h01, {7'h00, i_pmbus_host_model.ack_ok});
      wr_chk(8'h10, 8'h40, 8'h40);
      wr_chk(8'h01, 8'h14, 8'h14);
      wr_chk(8'h02, 8'h08, 8'h17);
      wr_chk(8'h10, 8'h20, 8'h20);
      wr_chk(8'h02, 8'h0C, 8'h1F);
      wr_chk(8'hD0, 8'h5A, 8'h00);
      chk("alert", 8'h00, {7'h00, alert_oe});
      wr_chk(8'h10, 8'h00, 8'h00);
      wr_chk(8'hD0, 8'h5A, 8'h5A);
      wr_chk(8'h02, 8'h17, 8'h17);
      wr_chk(8'h10, 8'h55, 8'h00);
      i_pmbus_host_model.rd(8'h78, rd_val);
      chk("comm flag", 8'h02, rd_val & 8'h02);
      clear_chk(1'b0);
      i_pmbus_host_model.xfer(8'h5A, 2'h1, 16'h0080);
      chk("alert", 8'h01, {7'h00, alert_oe});
      rd_chk(8'h01, 8'h14);
      chk("margin", 8'h05, {4'h0, margin});
      clear_chk(1'b0);
      i_pmbus_host_model.xfer(8'h01, 2'h2, 16'h8080);
      rd_chk(8'h01, 8'h14);
      fault = 7'h04;
      clear_chk(1'b1);
      fault = 7'h00;
      clear_chk(1'b0);
      i_pmbus_host_model.xfer(8'h11, 2'h0, 16'h0000);
      wait_idle;
      chk("busy seen", 8'h01, {7'h00, seen_busy});
      wr_chk(8'h01, 8'h00, 8'h00);
      wr_chk(8'h02, 8'h08, 8'h1B);
      i_pmbus_host_model.xfer(8'h12, 2'h0, 16'h0000);
      wait_idle;
      rd_chk(8'h01, 8'h14);
      rd_chk(8'h02, 8'h17);
      chk("margin", 8'h05, {4'h0, margin});
      reset_chk;
      report_and_stop;
   end
   initial begin
      #600000;
      fail_count = fail_count + 1;
      report_and_stop;
   end
endmodule
`default_nettype wire
